// ---- core/fsl_pkg.sv ----
package fsl_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_PAUSE = 8'h75;
  localparam logic [7:0] OP_CONT = 8'h7A;
  localparam logic [7:0] OP_OTP_ER = 8'h44;
  localparam logic [7:0] OP_OTP_PG = 8'h42;
  localparam logic [7:0] OP_OTP_RD = 8'h48;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_RD_LOCK = 8'h3D;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hC7;
  // security area address fields
  localparam logic [7:0] OTP_HI = 8'h00;
  localparam logic [3:0] OTP_SEL_LO = 4'h1;
  localparam logic [3:0] OTP_SEL_HI = 4'h3;
  localparam logic [2:0] OTP_PAD = 3'h0;
  localparam int OTP_AREAS = 3;
  localparam int OTP_BYTES = 512;
  localparam logic [8:0] OTP_LAST = 9'h1FF;
  localparam logic [7:0] ERASED = 8'hFF;
  // frame byte counts
  localparam logic [2:0] CNT_ADDR = 3'h3;
  localparam logic [2:0] CNT_DATA = 3'h4;
  localparam logic [2:0] CNT_SAT = 3'h5;
  localparam int TMR_W = 16;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int RESUME_NS = 200;
  localparam int RESUME_CYC = RESUME_NS * CLK_MHZ / 1000;
  localparam int SUS_IDX_PROG = 1;
  localparam int SUS_IDX_ERASE = 0;

  typedef enum logic [2:0] {
    K_NONE, K_MAIN_PG, K_MAIN_ER, K_OTP_PG, K_OTP_ER
  } fsl_kind_t;

  typedef struct packed {
    logic write_in_progress;
    logic write_enable_latch;
    logic [1:0] suspend_flags;
  } fsl_status_t;

  typedef struct packed {
    logic protect_scheme_select;
    logic protect_complement;
    logic [4:0] protect_range_bits;
  } fsl_prot_t;
endpackage : fsl_pkg

// ---- core/fsl_core.sv ----
// Function
// - pause opcode suspends an ongoing page program or block erase
// - no status write, security erase/program, erase or program while paused
// - pause taken only if suspend flags clear and busy with program/erase
// - pause sets suspend flag at once, clears busy within suspend latency
// - reset clears any paused operation
// - continue taken only with a suspend flag set and not busy
// - continue clears suspend flag and raises busy within 200 ns
// - three separate 512-byte security areas, erased and programmed alone
// - security erase only when chip select rises on a byte boundary
// - security erase and program need the write enable latch set
// - chip select rise starts timed cycle; busy during it; latch cleared
// - a set lock bit makes security erase and program ignored
// - security address: 00, area 1..3, zero pad, nine-bit byte address
// - security read: address, dummy byte, data out on falling edges
// - read address increments and wraps within the area byte field
// - lock bits govern only with scheme select set, else range bits
// - lock bits volatile, all set after reset
// - lock command plus 24-bit address sets that block lock bit
// - unlock command plus 24-bit address clears that block lock bit
// - read-lock returns lock state in the lowest bit
// - commands other than pause during a busy cycle are ignored and do not disturb it
`timescale 1ns/1ps
module fsl_core import fsl_pkg::*; #(
  parameter int LOCK_BLOCKS = 256,
  parameter int PROG_CYC = 64,
  parameter int ERASE_CYC = 1024,
  parameter int OTP_PROG_CYC = 64,
  parameter int OTP_ERASE_CYC = 1024
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  // protection configuration
  input wire logic [2:0] otp_lock_bits,
  input wire fsl_prot_t prot_cfg,
  // status
  output fsl_status_t status
);
  localparam int LBW = $clog2(LOCK_BLOCKS);
  localparam int RES_LIM = RESUME_CYC;

  function automatic logic otp_ok(input logic [23:0] a);
    return a[23:16] == OTP_HI && a[15:12] >= OTP_SEL_LO &&
      a[15:12] <= OTP_SEL_HI && a[11:9] == OTP_PAD;
  endfunction : otp_ok

  function automatic logic [1:0] area_of(input logic [23:0] a);
    return a[13:12] - 2'h1;
  endfunction : area_of

  function automatic logic [10:0] otp_idx(input logic [23:0] a,
                                          input logic [8:0] off);
    return {area_of(a), off};
  endfunction : otp_idx

  function automatic logic [LBW-1:0] blk_of(input logic [23:0] a);
    return a[23 -: LBW];
  endfunction : blk_of

  // top 2^(n-1) of 256 blocks, inverted by the complement bit
  function automatic logic range_hit(input logic [7:0] b,
                                     input fsl_prot_t c);
    logic [2:0] n;
    n = c.protect_range_bits[2:0];
    return c.protect_complement ^ (n != 3'h0 &&
      (b >> (n - 3'h1)) == (8'hFF >> (n - 3'h1)));
  endfunction : range_hit

  // ---------------- link domain (sclk) ----------------
  logic link_clr;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q, rx_byte_q;
  logic [8:0] tx_sh_q, tx_q;
  logic rx_tog_q, partial_q, so_q, so_oe_q;

  assign link_clr = rst | cs_n;

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // tx_q only changes well inside a byte, so loading it at the
  // boundary is safe; the toggle orders the exchange
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_sh_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_tog_q <= 1'b0;
      partial_q <= 1'b0;
      tx_sh_q <= 9'h000;
    end else begin
      rx_sh_q <= {rx_sh_q[6:0], si};
      partial_q <= (bit_cnt_q != 3'h7);
      if (bit_cnt_q == 3'h7) begin
        rx_byte_q <= {rx_sh_q[6:0], si};
        rx_tog_q <= ~rx_tog_q;
        tx_sh_q <= tx_q;
      end
    end
  end

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q <= tx_sh_q[~bit_cnt_q];
      so_oe_q <= tx_sh_q[8];
    end
  end
  assign so_o = so_q;
  assign so_oe = so_oe_q;

  // ---------------- core domain (clk) ----------------
  logic cs_s1_q, cs_s2_q, cs_s3_q, tg_s1_q, tg_s2_q, tg_s3_q;
  logic pt_s1_q, pt_s2_q, end_q;
  logic cs_fall, byte_ev, aligned;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      pt_s1_q <= 1'b0;
      pt_s2_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tg_s1_q <= rx_tog_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      pt_s1_q <= partial_q;
      pt_s2_q <= pt_s1_q;
      // one cycle late so the last byte event is always seen first
      end_q <= cs_s2_q & ~cs_s3_q;
    end
  end
  assign cs_fall = ~cs_s2_q & cs_s3_q;
  assign byte_ev = tg_s2_q ^ tg_s3_q;
  assign aligned = ~pt_s2_q;

  // frame parsing
  logic [2:0] cnt_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q, addr_nx;
  assign addr_nx = {addr_q[15:0], rx_byte_q};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (cs_fall) begin
      cnt_q <= 3'h0;
    end else if (byte_ev) begin
      if (cnt_q == 3'h0) begin
        opc_q <= rx_byte_q;
      end else if (cnt_q <= CNT_ADDR) begin
        addr_q <= addr_nx;
      end
      if (cnt_q != CNT_SAT) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // operation state
  logic busy_q, wel_q;
  logic [1:0] sus_q;
  fsl_kind_t kind_q;
  logic [TMR_W-1:0] tmr_q;
  logic [LOCK_BLOCKS-1:0] lock_q;
  logic [9:0] sweep_q;
  logic [1:0] er_area_q;
  logic prog_go_q;
  logic [8:0] wr_ptr_q, rd_ptr_q;
  logic rd_act_q;
  logic [7:0] mem [0:OTP_AREAS*OTP_BYTES-1];

  logic idle_ok, chip_prot, main_prot, main_cmd, main_er;
  logic main_acc, otp_er_acc, otp_pg_acc, pause_acc, cont_acc;
  logic write_latch_set_cmd_acc, wrdi_acc, lock_acc, er_wr, pg_wr;

  assign idle_ok = end_q & ~busy_q & aligned;
  assign chip_prot = prot_cfg.protect_scheme_select ? |lock_q :
    prot_cfg.protect_range_bits != 5'h00;
  assign main_er = opc_q inside {OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
  assign main_cmd =
    (opc_q inside {OP_PP, OP_QPP} && cnt_q == CNT_SAT) ||
    (opc_q inside {OP_SE, OP_BE32, OP_BE64} && cnt_q == CNT_DATA) ||
    (opc_q inside {OP_CE1, OP_CE2} && cnt_q == 3'h1);
  assign main_prot = (opc_q inside {OP_CE1, OP_CE2}) ? chip_prot :
    prot_cfg.protect_scheme_select ? lock_q[blk_of(addr_q)] :
    range_hit(addr_q[23:16], prot_cfg);
  assign main_acc = idle_ok & sus_q == 2'h0 & wel_q & main_cmd &
    ~main_prot;
  assign otp_er_acc = idle_ok & sus_q == 2'h0 & wel_q &
    opc_q == OP_OTP_ER & cnt_q == CNT_DATA & otp_ok(addr_q) &
    ~otp_lock_bits[area_of(addr_q)];
  assign otp_pg_acc = end_q & ~busy_q & prog_go_q & cnt_q == CNT_SAT;
  assign pause_acc = end_q & aligned & opc_q == OP_PAUSE &
    cnt_q == 3'h1 & busy_q & sus_q == 2'h0 &
    (kind_q inside {K_MAIN_PG, K_MAIN_ER});
  assign cont_acc = end_q & aligned & opc_q == OP_CONT &
    cnt_q == 3'h1 & sus_q != 2'h0 & ~busy_q;
  assign write_latch_set_cmd_acc = idle_ok & opc_q == OP_WRITE_LATCH_SET_CMD & cnt_q == 3'h1;
  assign wrdi_acc = idle_ok & opc_q == OP_WRDI & cnt_q == 3'h1;
  assign lock_acc = idle_ok & (opc_q inside {OP_LOCK, OP_UNLOCK}) &
    cnt_q == CNT_DATA;
  assign er_wr = busy_q & kind_q == K_OTP_ER & ~sweep_q[9];
  assign pg_wr = byte_ev & prog_go_q & cnt_q >= CNT_DATA;

  // busy, latch, suspend and cycle timer; reset drops any pause
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      wel_q <= 1'b0;
      sus_q <= 2'h0;
      kind_q <= K_NONE;
      tmr_q <= '0;
    end else if (main_acc | otp_er_acc | otp_pg_acc) begin
      busy_q <= 1'b1;
      wel_q <= 1'b0;
      if (otp_er_acc) begin
        kind_q <= K_OTP_ER;
        tmr_q <= TMR_W'(OTP_ERASE_CYC);
      end else if (otp_pg_acc) begin
        kind_q <= K_OTP_PG;
        tmr_q <= TMR_W'(OTP_PROG_CYC);
      end else if (main_er) begin
        kind_q <= K_MAIN_ER;
        tmr_q <= TMR_W'(ERASE_CYC);
      end else begin
        kind_q <= K_MAIN_PG;
        tmr_q <= TMR_W'(PROG_CYC);
      end
    end else if (pause_acc) begin
      busy_q <= 1'b0;
      unique case (kind_q)
        K_MAIN_PG: sus_q[SUS_IDX_PROG] <= 1'b1;
        K_MAIN_ER: sus_q[SUS_IDX_ERASE] <= 1'b1;
        default: sus_q <= sus_q;
      endcase
    end else if (cont_acc) begin
      sus_q <= 2'h0;
      busy_q <= 1'b1;
    end else begin
      if (write_latch_set_cmd_acc) begin
        wel_q <= 1'b1;
      end else if (wrdi_acc) begin
        wel_q <= 1'b0;
      end
      if (busy_q) begin
        if (tmr_q == '0) begin
          busy_q <= 1'b0;
          kind_q <= K_NONE;
        end else begin
          tmr_q <= tmr_q - 1'b1;
        end
      end
    end
  end

  // volatile block locks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_q <= '1;
    end else if (lock_acc) begin
      lock_q[blk_of(addr_q)] <= (opc_q == OP_LOCK);
    end
  end

  // security area erase sweeps one byte per cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sweep_q <= 10'h200;
      er_area_q <= 2'h0;
    end else if (otp_er_acc) begin
      sweep_q <= 10'h000;
      er_area_q <= area_of(addr_q);
    end else if (er_wr) begin
      sweep_q <= sweep_q + 10'h001;
    end
  end

  // program bytes are merged while they stream in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_go_q <= 1'b0;
      wr_ptr_q <= 9'h000;
    end else if (cs_fall) begin
      prog_go_q <= 1'b0;
    end else if (byte_ev && cnt_q == CNT_ADDR) begin
      prog_go_q <= opc_q == OP_OTP_PG && !busy_q && sus_q == 2'h0 &&
        wel_q && otp_ok(addr_nx) &&
        !otp_lock_bits[area_of(addr_nx)];
      wr_ptr_q <= addr_nx[8:0];
    end else if (pg_wr) begin
      wr_ptr_q <= wr_ptr_q + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (er_wr) begin
      mem[{er_area_q, sweep_q[8:0]}] <= ERASED;
    end else if (pg_wr) begin
      mem[otp_idx(addr_q, wr_ptr_q)] <=
        mem[otp_idx(addr_q, wr_ptr_q)] & rx_byte_q;
    end
  end

  // read data prepared one byte ahead of the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q <= 9'h000;
      rd_ptr_q <= 9'h000;
      rd_act_q <= 1'b0;
    end else if (cs_fall) begin
      tx_q <= 9'h000;
      rd_act_q <= 1'b0;
    end else if (byte_ev) begin
      if (cnt_q == CNT_ADDR && !busy_q) begin
        if (opc_q == OP_OTP_RD && otp_ok(addr_nx)) begin
          tx_q <= {1'b1, mem[otp_idx(addr_nx, addr_nx[8:0])]};
          rd_ptr_q <= addr_nx[8:0] + 9'h001;
          rd_act_q <= 1'b1;
        end else if (opc_q == OP_RD_LOCK) begin
          tx_q <= {1'b1, 7'h00, lock_q[blk_of(addr_nx)]};
        end
      end else if (rd_act_q && cnt_q >= CNT_DATA) begin
        tx_q <= {1'b1, mem[otp_idx(addr_q, rd_ptr_q)]};
        rd_ptr_q <= rd_ptr_q + 9'h001;
      end
    end
  end

  assign status = {busy_q, wel_q, sus_q};

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pause;
    pause_acc |=> sus_q != 2'h0 && !busy_q && $stable(tmr_q);
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause did not set suspend and drop busy");

  property p_pause_ign;
    end_q && opc_q == OP_PAUSE && (!busy_q || sus_q != 2'h0)
      |=> $stable(sus_q);
  endproperty
  a_pause_ign: assert property (p_pause_ign)
    else $error("ignored pause changed suspend flags");

  property p_cont;
    cont_acc |=> sus_q == 2'h0 ##[0:RES_LIM] busy_q;
  endproperty
  a_cont: assert property (p_cont)
    else $error("continue did not restore busy in time");

  property p_cont_ign;
    end_q && opc_q == OP_CONT && sus_q == 2'h0 && !busy_q
      |=> !busy_q;
  endproperty
  a_cont_ign: assert property (p_cont_ign)
    else $error("continue without pause started a cycle");

  property p_otp_start;
    otp_er_acc || otp_pg_acc |=> busy_q && !wel_q;
  endproperty
  a_otp_start: assert property (p_otp_start)
    else $error("security cycle start wrong");

  property p_otp_locked;
    end_q && opc_q == OP_OTP_ER && otp_ok(addr_q) && !busy_q &&
      otp_lock_bits[area_of(addr_q)] |=> !busy_q;
  endproperty
  a_otp_locked: assert property (p_otp_locked)
    else $error("erase ran on a locked security area");

  property p_wrap;
    byte_ev && rd_act_q && cnt_q >= CNT_DATA && rd_ptr_q == OTP_LAST
      |=> rd_ptr_q == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("read address did not wrap");

  property p_lock_reset;
    $past(rst) |-> &lock_q;
  endproperty
  a_lock_reset: assert property (p_lock_reset)
    else $error("lock bits not all set after reset");

  property p_busy_lock;
    busy_q && end_q |=> $stable(lock_q);
  endproperty
  a_busy_lock: assert property (p_busy_lock)
    else $error("lock changed during busy cycle");

  property p_rd_lock;
    byte_ev && cnt_q == CNT_ADDR && opc_q == OP_RD_LOCK && !busy_q
      |=> tx_q[0] == lock_q[blk_of(addr_q)] && tx_q[8];
  endproperty
  a_rd_lock: assert property (p_rd_lock)
    else $error("read-lock answer wrong");

  property p_prot;
    end_q && main_cmd && main_prot && !busy_q |=> !busy_q;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected block started a cycle");

  c_pause_cont: cover property (pause_acc ##[1:1000] cont_acc);
  c_prog_pause: cover property (pause_acc && kind_q == K_MAIN_PG);
  c_wrap: cover property (byte_ev && rd_act_q && rd_ptr_q == OTP_LAST);
  c_otp_er: cover property (otp_er_acc);
endmodule : fsl_core

// ---- tb/fsl_host.sv ----
`timescale 1ns/1ps
module fsl_host (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_o,
  input wire logic so_oe
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:3];
  int n_oe;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // whole bytes only, so cs_n always rises on a byte boundary
  task automatic frame(input int ntx, input int nrx);
    int i;
    int b;
    cs_n = 1'b0;
    n_oe = 0;
    for (i = 0; i < ntx + nrx; i++) begin
      for (b = 7; b >= 0; b--) begin
        // read phase: si toggles so nothing rests on a stale bit
        si = (i < ntx) ? tx[i][b] : ~si;
        #6 sclk = 1'b1;
        if (i >= ntx) begin
          rx[i - ntx][b] = so_o;
          n_oe += int'(so_oe);
        end
        #6 sclk = 1'b0;
      end
    end
    #6 cs_n = 1'b1;
    si = ~si;
    // link clock stands still between frames
    #60;
  endtask : frame
endmodule : fsl_host

// ---- tb/flash_suspend_otp_sector_lock_test.sv ----
`timescale 1ns/1ps
module flash_suspend_otp_sector_lock_test;
  import fsl_pkg::*;
  logic clk;
  logic rst;
  logic sclk;
  logic cs_n;
  logic si;
  logic so_o;
  logic so_oe;
  logic [2:0] otp_lock_bits;
  fsl_prot_t prot_cfg;
  fsl_status_t status;
  int miscompares;
  int n_checks;

  fsl_host h (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o),
    .so_oe(so_oe));
  fsl_core #(.PROG_CYC(64), .ERASE_CYC(1024), .OTP_PROG_CYC(32),
    .OTP_ERASE_CYC(512)) uut (.clk(clk), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe),
    .otp_lock_bits(otp_lock_bits), .prot_cfg(prot_cfg), .status(status));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : check

  // status as {busy, latch, program paused, erase paused}
  task automatic st(input logic [3:0] exp);
    repeat (8) @(negedge clk);
    check("status", {4'h0, exp}, {4'h0, status});
  endtask : st

  task automatic cmd1(input logic [7:0] op);
    h.tx[0] = op;
    h.frame(1, 0);
  endtask : cmd1

  task automatic cmd4(input logic [7:0] op, input logic [23:0] a);
    h.tx[0] = op;
    h.tx[1] = a[23:16];
    h.tx[2] = a[15:8];
    h.tx[3] = a[7:0];
    h.frame(4, 0);
  endtask : cmd4

  task automatic rd_lock(input logic [23:0] a, input logic [7:0] exp);
    h.tx[0] = OP_RD_LOCK;
    h.tx[1] = a[23:16];
    h.tx[2] = a[15:8];
    h.tx[3] = a[7:0];
    h.frame(4, 2);
    check("lock byte", exp, h.rx[1]);
  endtask : rd_lock

  // host polls busy low before further writes, except the commands sent on purpose during a busy cycle
  task automatic wait_idle(input int n);
    int i;
    for (i = 0; i < n && status.write_in_progress !== 1'b0; i++)
      @(negedge clk);
    check("busy end", 8'h00, {7'h0, status.write_in_progress});
  endtask : wait_idle

  task automatic t_lock;
    st(4'h0);
    rd_lock(24'h030000, 8'h01);
    cmd4(OP_UNLOCK, 24'h050000);
    rd_lock(24'h050000, 8'h00);
    cmd4(OP_LOCK, 24'h050000);
    rd_lock(24'h050000, 8'h01);
    $display("test lock done");
  endtask : t_lock

  task automatic t_otp;
    cmd4(OP_OTP_ER, 24'h002000);
    st(4'h0);
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_OTP_ER, 24'h002000);
    st(4'h8);
    wait_idle(600);
    cmd1(OP_WRITE_LATCH_SET_CMD);
    h.tx[0] = OP_OTP_PG;
    h.tx[1] = 8'h00;
    h.tx[2] = 8'h21;
    h.tx[3] = 8'hFF;
    h.tx[4] = 8'hA5;
    h.tx[5] = 8'h3C;
    h.frame(6, 0);
    st(4'h8);
    wait_idle(100);
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_OTP_ER, 24'h001000);
    wait_idle(600);
    // start one byte below the field end so the read crosses the wrap
    h.tx[0] = OP_OTP_RD;
    h.tx[1] = 8'h00;
    h.tx[2] = 8'h21;
    h.tx[3] = 8'hFE;
    h.tx[4] = 8'h00;
    h.frame(5, 3);
    check("otp erased", 8'hFF, h.rx[0]);
    check("otp byte", 8'hA5, h.rx[1]);
    check("otp wrap", 8'h3C, h.rx[2]);
    check("oe bits", 8'd24, 8'(h.n_oe));
    @(negedge clk) otp_lock_bits <= 3'h2;
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_OTP_ER, 24'h002000);
    st(4'h4);
    cmd1(OP_WRDI);
    @(negedge clk) otp_lock_bits <= 3'h0;
    $display("test otp done");
  endtask : t_otp

  task automatic t_suspend;
    @(negedge clk) prot_cfg <= '{1'b1, 1'b0, 5'h00};
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_BE64, 24'h000000);
    st(4'h4);
    @(negedge clk) prot_cfg <= '{1'b0, 1'b0, 5'h00};
    cmd4(OP_BE64, 24'h000000);
    st(4'h8);
    cmd1(OP_CONT);
    st(4'h8);
    cmd4(OP_UNLOCK, 24'h000000);
    cmd1(OP_PAUSE);
    st(4'h1);
    cmd1(OP_PAUSE);
    st(4'h1);
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_OTP_ER, 24'h002000);
    st(4'h5);
    cmd1(OP_CONT);
    repeat (RESUME_CYC) @(negedge clk);
    check("resume", 8'h08, {4'h0, status} & 8'h09);
    wait_idle(1100);
    rd_lock(24'h000000, 8'h01);
    cmd1(OP_PAUSE);
    check("idle pause", 8'h00, {6'h0, status.suspend_flags});
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_BE64, 24'h000000);
    cmd1(OP_PAUSE);
    st(4'h1);
    @(negedge clk) rst <= 1'b1;
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    st(4'h0);
    cmd1(OP_CONT);
    st(4'h0);
    rd_lock(24'h000000, 8'h01);
    $display("test suspend done");
  endtask : t_suspend

  // range protection, complement, chip erase and a paused page program
  task automatic t_range;
    @(negedge clk) prot_cfg <= '{1'b0, 1'b0, 5'h01};
    cmd1(OP_WRITE_LATCH_SET_CMD);
    cmd4(OP_SE, 24'hFF0000);
    st(4'h4);
    @(negedge clk) prot_cfg <= '{1'b0, 1'b1, 5'h01};
    cmd1(OP_CE2);
    st(4'h4);
    cmd4(OP_SE, 24'hFF0000);
    st(4'h8);
    wait_idle(1100);
    @(negedge clk) prot_cfg <= '{1'b0, 1'b0, 5'h00};
    cmd1(OP_WRITE_LATCH_SET_CMD);
    h.tx[0] = OP_PP;
    h.tx[1] = 8'h10;
    h.tx[2] = 8'h00;
    h.tx[3] = 8'h00;
    h.tx[4] = 8'h5A;
    h.frame(5, 0);
    cmd1(OP_PAUSE);
    st(4'h2);
    cmd1(OP_CONT);
    wait_idle(100);
    $display("test range done");
  endtask : t_range

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial begin
    rst = 1'b1;
    otp_lock_bits = 3'h0;
    prot_cfg = '{1'b1, 1'b0, 5'h00};
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(negedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    t_lock();
    t_otp();
    t_suspend();
    t_range();
    final_report();
  end

  // whole run is a few dozen frames plus two security erase sweeps and two full main erases
  initial begin
    #300us;
    miscompares++;
    final_report();
  end
endmodule : flash_suspend_otp_sector_lock_test
